// File: ddg_dram_model.sv
// Behavioural memory device model that checks the spacing of the commands it receives.
module ddg_dram_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [2:0] bank,
  output int errs
);
  timeunit 1ns;
  timeprecision 1ns;
  int now, t_act, t_col, t_mrs, t_ref, t_mpr, t_cke, t_up, t_srx;
  int t_rd [8];
  logic cke_q;
  task automatic need(input int got, input int lim);
    if (got < lim) errs++;
  endtask : need
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      now = 0;
      errs = 0;
      {t_act, t_col, t_mrs, t_ref, t_mpr, t_srx} = {6{-999}};
      t_rd = '{default: -999};
      t_cke = 0;
      t_up = 0;
      cke_q = 0;
    end else begin
      now++;
      // An exit from self-refresh needs one cycle more of low level than a plain pulse.
      if (cke != cke_q) begin
        need(now - t_cke, (cmd == 4'hc) ? 4 : 3);
        t_cke = now;
        // A power-down exit carries no such wait, so it does not restart the exit count.
        if (cke && cmd != 4'he) t_up = now;
      end
      cke_q = cke;
      if (cmd != 4'h0) need(now - t_mpr, 2);
      if (cmd != 4'h0 && cmd != 4'h8) need(now - t_mrs, 12);
      if (cmd != 4'h0 && cmd != 4'hc && cmd != 4'he) need(now - t_up, 6);
      if (cmd inside {4'h2, 4'h3, 4'h9, 4'ha}) need(now - t_srx, 512);
      case (cmd)
        4'h1: begin
          need(now - t_act, 4);
          need(now - t_ref, 6);
          t_act = now;
        end
        4'h2, 4'h4: begin
          need(now - t_col, 4);
          t_col = now;
          if (cmd == 4'h2) t_rd[bank] = now;
        end
        4'h6: need(now - t_rd[bank], 4);
        4'h7: begin
          need(now - t_ref, 6);
          t_ref = now;
        end
        4'h8: begin
          need(now - t_mrs, 4);
          t_mrs = now;
        end
        4'h9: t_mpr = now;
        4'hc: t_srx = now;
        default: ;
      endcase
    end
  end
endmodule : ddg_dram_model

// File: ddg_gap_timer.sv
// Down-counting gap timer; a load only ever lengthens the wait already running.
module ddg_gap_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [ddg_pkg::TW-1:0] value,
  output logic idle
);

  typedef struct packed {
    logic [ddg_pkg::TW-1:0] count;
  } ddg_timer_t;

  ddg_timer_t st;
  ddg_timer_t next_st;
  logic [ddg_pkg::TW-1:0] dec;

  always_comb begin
    dec = (st.count != '0) ? st.count - 10'h001 : st.count;
    next_st.count = dec;
    if (load && value > dec) begin
      next_st.count = value;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign idle = (st.count == '0);

endmodule : ddg_gap_timer

// File: ddg_guard.sv
// Controller-side DDR3 command spacing guard with clock-enable and refresh pacing.
module ddg_guard (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CMD_VALID,
  input wire logic [3:0] CMD_CODE,
  input wire logic [2:0] CMD_BANK,
  output logic CMD_READY,
  input wire logic [3:0] CFG_READ_LATENCY,
  input wire logic [3:0] CFG_WRITE_LATENCY,
  input wire logic CFG_DLL_OFF,
  output logic CFG_OK,
  input wire logic TEMP_HOT,
  output logic REFRESH_DUE,
  input wire logic CK_RUNNING,
  output logic CK_HOLD,
  output logic DRAM_CKE,
  output logic [3:0] DRAM_CMD,
  output logic [2:0] DRAM_BANK
);

  typedef struct packed {
    ddg_pkg::ddg_state_t state;
    logic armed;
    logic cke;
    logic [3:0] cmd;
    logic [2:0] bank;
    logic [1:0] faw_ptr;
    logic [7:0] refi_cnt;
    logic refresh_due;
    logic cfg_ok;
  } ddg_guard_t;

  ddg_guard_t st;
  ddg_guard_t next_st;
  logic [ddg_pkg::NT-1:0] tload;
  logic [ddg_pkg::NT-1:0] tidle;
  logic [ddg_pkg::TW-1:0] tval [ddg_pkg::NT];
  logic acc;
  logic col_ok;
  logic ready;
  ddg_pkg::ddg_cmd_t cmd;

  function automatic int bidx(input int k, input logic [2:0] b);
    return ddg_pkg::NG + k * ddg_pkg::NB + int'(b);
  endfunction : bidx

  function automatic int fidx(input logic [1:0] p);
    return ddg_pkg::NG + ddg_pkg::NK * ddg_pkg::NB + int'(p);
  endfunction : fidx

  function automatic logic [ddg_pkg::TW-1:0] wait_of(input int n);
    return ddg_pkg::TW'(n - 1);
  endfunction : wait_of

  // Every spacing lives in its own timer so that unrelated gaps overlap freely.
  genvar gi;
  generate
    for (gi = 0; gi < ddg_pkg::NT; gi++) begin : g_timer
      ddg_gap_timer u_timer (
        .clk(CLK),
        .rst_b(RST_B),
        .load(tload[gi]),
        .value(tval[gi]),
        .idle(tidle[gi])
      );
    end
  endgenerate

  assign cmd = ddg_pkg::ddg_cmd_t'(CMD_CODE);
  assign acc = CMD_VALID && ready;

  always_comb begin
    next_st = st;
    tload = '0;
    for (int i = 0; i < ddg_pkg::NT; i++) begin
      tval[i] = '0;
    end
    ready = 1'b0;
    // Column commands need the open row, the column gap and no pending setting.
    col_ok = tidle[bidx(ddg_pkg::K_RCD, CMD_BANK)] && tidle[ddg_pkg::G_CCD];
    col_ok = col_ok && tidle[ddg_pkg::G_MPR] && tidle[ddg_pkg::G_MOD];
    col_ok = col_ok && tidle[ddg_pkg::G_XS];
    next_st.cfg_ok = ddg_pkg::pair_ok(CFG_READ_LATENCY, CFG_WRITE_LATENCY, CFG_DLL_OFF);
    if (st.state == ddg_pkg::ST_RUN) begin
      unique case (cmd)
        ddg_pkg::CMD_NOP: ready = 1'b1;
        ddg_pkg::CMD_ACT: ready = tidle[bidx(ddg_pkg::K_RC, CMD_BANK)] &&
          tidle[bidx(ddg_pkg::K_RP, CMD_BANK)] && tidle[ddg_pkg::G_RRD] &&
          tidle[fidx(st.faw_ptr)] && tidle[ddg_pkg::G_RFC] &&
          tidle[ddg_pkg::G_MOD] && tidle[ddg_pkg::G_XS] && tidle[ddg_pkg::G_MPR];
        ddg_pkg::CMD_RD, ddg_pkg::CMD_RDA, ddg_pkg::CMD_MPR:
          ready = col_ok && tidle[ddg_pkg::G_WTR] && tidle[ddg_pkg::G_DLL];
        ddg_pkg::CMD_WR, ddg_pkg::CMD_WRA: ready = col_ok;
        ddg_pkg::CMD_PRE: ready = tidle[bidx(ddg_pkg::K_RAS, CMD_BANK)] &&
          tidle[bidx(ddg_pkg::K_RTP, CMD_BANK)] && tidle[ddg_pkg::G_MOD] &&
          tidle[ddg_pkg::G_XS] && tidle[ddg_pkg::G_MPR];
        ddg_pkg::CMD_REF: ready = tidle[ddg_pkg::G_RFC] && tidle[ddg_pkg::G_MOD] &&
          tidle[ddg_pkg::G_XS] && tidle[ddg_pkg::G_MPR];
        ddg_pkg::CMD_MRS: ready = tidle[ddg_pkg::G_MRD] && tidle[ddg_pkg::G_XS] &&
          tidle[ddg_pkg::G_MPR];
        ddg_pkg::CMD_ODT: ready = tidle[ddg_pkg::G_DLL] && tidle[ddg_pkg::G_MOD] &&
          tidle[ddg_pkg::G_XS];
        ddg_pkg::CMD_SRE, ddg_pkg::CMD_PDE: ready = tidle[ddg_pkg::G_CKE] &&
          tidle[ddg_pkg::G_MOD] && tidle[ddg_pkg::G_RFC] && tidle[ddg_pkg::G_XS];
        default: ready = 1'b0;
      endcase
    end else if (st.state == ddg_pkg::ST_SELF) begin
      ready = (cmd == ddg_pkg::CMD_SRX) && tidle[ddg_pkg::G_CKESR] &&
        tidle[ddg_pkg::G_CKE] && tidle[ddg_pkg::G_CKVALID] && CK_RUNNING;
    end else if (st.state == ddg_pkg::ST_DOWN) begin
      ready = (cmd == ddg_pkg::CMD_PDX) && tidle[ddg_pkg::G_CKE] &&
        tidle[ddg_pkg::G_CKVALID] && CK_RUNNING;
    end
    // The clock must have run for a while before a self-refresh or power-down exit is allowed.
    tload[ddg_pkg::G_CKVALID] = !CK_RUNNING;
    tval[ddg_pkg::G_CKVALID] = wait_of(ddg_pkg::N_CKSRX);
    next_st.cmd = acc ? CMD_CODE : ddg_pkg::CMD_NOP;
    next_st.bank = acc ? CMD_BANK : st.bank;
    if (acc) begin
      unique case (cmd)
        ddg_pkg::CMD_ACT: begin
          tload[bidx(ddg_pkg::K_RCD, CMD_BANK)] = 1'b1;
          tval[bidx(ddg_pkg::K_RCD, CMD_BANK)] = wait_of(ddg_pkg::N_RCD);
          tload[bidx(ddg_pkg::K_RC, CMD_BANK)] = 1'b1;
          tval[bidx(ddg_pkg::K_RC, CMD_BANK)] = wait_of(ddg_pkg::N_RC);
          tload[bidx(ddg_pkg::K_RAS, CMD_BANK)] = 1'b1;
          tval[bidx(ddg_pkg::K_RAS, CMD_BANK)] = wait_of(ddg_pkg::N_RAS);
          tload[ddg_pkg::G_RRD] = 1'b1;
          tval[ddg_pkg::G_RRD] = wait_of(ddg_pkg::N_RRD);
          tload[fidx(st.faw_ptr)] = 1'b1;
          tval[fidx(st.faw_ptr)] = wait_of(ddg_pkg::N_FAW);
          next_st.faw_ptr = st.faw_ptr + 2'h1;
        end
        ddg_pkg::CMD_RD, ddg_pkg::CMD_RDA, ddg_pkg::CMD_MPR: begin
          tload[ddg_pkg::G_CCD] = 1'b1;
          tval[ddg_pkg::G_CCD] = wait_of(ddg_pkg::N_CCD);
          tload[bidx(ddg_pkg::K_RTP, CMD_BANK)] = 1'b1;
          tval[bidx(ddg_pkg::K_RTP, CMD_BANK)] = wait_of(ddg_pkg::N_RTP);
          tload[ddg_pkg::G_MPR] = (cmd == ddg_pkg::CMD_MPR);
          tval[ddg_pkg::G_MPR] = wait_of(ddg_pkg::N_MPRR + 1);
        end
        ddg_pkg::CMD_WR, ddg_pkg::CMD_WRA: begin
          tload[ddg_pkg::G_CCD] = 1'b1;
          tval[ddg_pkg::G_CCD] = wait_of(ddg_pkg::N_CCD);
          // The internal write begins write latency plus four clocks later.
          tload[ddg_pkg::G_WTR] = 1'b1;
          tval[ddg_pkg::G_WTR] = ddg_pkg::TW'(CFG_WRITE_LATENCY) +
            wait_of(ddg_pkg::N_WTR + ddg_pkg::T_WR_START_NCK);
        end
        ddg_pkg::CMD_PRE: begin
          tload[bidx(ddg_pkg::K_RP, CMD_BANK)] = 1'b1;
          tval[bidx(ddg_pkg::K_RP, CMD_BANK)] = wait_of(ddg_pkg::N_RP);
        end
        ddg_pkg::CMD_REF: begin
          tload[ddg_pkg::G_RFC] = 1'b1;
          tval[ddg_pkg::G_RFC] = wait_of(ddg_pkg::N_RFC);
        end
        ddg_pkg::CMD_MRS: begin
          tload[ddg_pkg::G_MRD] = 1'b1;
          tval[ddg_pkg::G_MRD] = wait_of(ddg_pkg::N_MRD);
          tload[ddg_pkg::G_MOD] = 1'b1;
          tval[ddg_pkg::G_MOD] = wait_of(ddg_pkg::N_MOD);
        end
        ddg_pkg::CMD_SRE, ddg_pkg::CMD_PDE: begin
          next_st.cke = 1'b0;
          next_st.state = (cmd == ddg_pkg::CMD_SRE) ? ddg_pkg::ST_SELF : ddg_pkg::ST_DOWN;
          tload[ddg_pkg::G_CKE] = 1'b1;
          tval[ddg_pkg::G_CKE] = wait_of(ddg_pkg::N_CKE);
          tload[ddg_pkg::G_CKESR] = 1'b1;
          tval[ddg_pkg::G_CKESR] = wait_of(ddg_pkg::N_CKESR);
          tload[ddg_pkg::G_CKHOLD] = 1'b1;
          tval[ddg_pkg::G_CKHOLD] = wait_of(ddg_pkg::N_CKSRE);
        end
        ddg_pkg::CMD_SRX, ddg_pkg::CMD_PDX: begin
          next_st.cke = 1'b1;
          next_st.state = ddg_pkg::ST_RUN;
          tload[ddg_pkg::G_CKE] = 1'b1;
          tval[ddg_pkg::G_CKE] = wait_of(ddg_pkg::N_CKE);
          tload[ddg_pkg::G_XS] = (cmd == ddg_pkg::CMD_SRX);
          tval[ddg_pkg::G_XS] = wait_of(ddg_pkg::N_XS);
          tload[ddg_pkg::G_DLL] = (cmd == ddg_pkg::CMD_SRX);
          tval[ddg_pkg::G_DLL] = wait_of(ddg_pkg::N_DLLK);
        end
        default: begin
        end
      endcase
    end
    // Reset exit: clock enable low a full pulse, then raised, then the exit wait.
    if (st.state == ddg_pkg::ST_INIT) begin
      next_st.armed = 1'b1;
      tload[ddg_pkg::G_CKE] = !st.armed;
      tval[ddg_pkg::G_CKE] = wait_of(ddg_pkg::N_CKE);
      if (st.armed && tidle[ddg_pkg::G_CKE] && CK_RUNNING) begin
        next_st.cke = 1'b1;
        next_st.state = ddg_pkg::ST_RUN;
        tload[ddg_pkg::G_CKE] = 1'b1;
        tload[ddg_pkg::G_XS] = 1'b1;
        tval[ddg_pkg::G_XS] = wait_of(ddg_pkg::N_XPR);
      end
    end
    // The device refreshes itself while in self-refresh, so the interval restarts.
    if ((acc && cmd == ddg_pkg::CMD_REF) || st.state == ddg_pkg::ST_SELF) begin
      next_st.refi_cnt = '0;
    end else if (st.refi_cnt != 8'hff) begin
      next_st.refi_cnt = st.refi_cnt + 8'h01;
    end
    next_st.refresh_due = (next_st.refi_cnt >= (TEMP_HOT ? 8'(ddg_pkg::N_REFI_HOT) :
      8'(ddg_pkg::N_REFI)));
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st.state <= ddg_pkg::ST_INIT;
      st.armed <= 1'b0;
      st.cke <= 1'b0;
      st.cmd <= ddg_pkg::CMD_NOP;
      st.bank <= 3'h0;
      st.faw_ptr <= 2'h0;
      st.refi_cnt <= 8'h00;
      st.refresh_due <= 1'b0;
      st.cfg_ok <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign CMD_READY = ready;
  assign CFG_OK = st.cfg_ok;
  assign REFRESH_DUE = st.refresh_due;
  assign CK_HOLD = (st.state == ddg_pkg::ST_RUN) || (st.state == ddg_pkg::ST_INIT) ||
    !tidle[ddg_pkg::G_CKHOLD];
  assign DRAM_CKE = st.cke;
  assign DRAM_CMD = st.cmd;
  assign DRAM_BANK = st.bank;

  // Helper counters that only the checks below read.
  logic [7:0] since_mrs;
  logic [9:0] since_srx;
  logic is_col;
  logic is_dll;
  assign is_col = acc && (cmd == ddg_pkg::CMD_RD || cmd == ddg_pkg::CMD_RDA ||
    cmd == ddg_pkg::CMD_WR || cmd == ddg_pkg::CMD_WRA || cmd == ddg_pkg::CMD_MPR);
  assign is_dll = acc && (cmd == ddg_pkg::CMD_RD || cmd == ddg_pkg::CMD_RDA ||
    cmd == ddg_pkg::CMD_MPR || cmd == ddg_pkg::CMD_ODT);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      since_mrs <= 8'hff;
      since_srx <= 10'h3ff;
    end else begin
      since_mrs <= (acc && cmd == ddg_pkg::CMD_MRS) ? 8'h01 :
        ((since_mrs == 8'hff) ? since_mrs : since_mrs + 8'h01);
      since_srx <= (acc && cmd == ddg_pkg::CMD_SRX) ? 10'h001 :
        ((since_srx == 10'h3ff) ? since_srx : since_srx + 10'h001);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_col_gap;
    is_col |=> !is_col [*3];
  endproperty
  a_col_gap: assert property (p_col_gap)
    else $error("column commands closer than four cycles");

  property p_mrs_gap;
    (acc && cmd == ddg_pkg::CMD_MRS) |=> !(acc && cmd == ddg_pkg::CMD_MRS) [*3];
  endproperty
  a_mrs_gap: assert property (p_mrs_gap)
    else $error("mode settings closer than four cycles");

  property p_mod_wait;
    (acc && cmd != ddg_pkg::CMD_MRS && cmd != ddg_pkg::CMD_NOP) |-> since_mrs >= 8'h0c;
  endproperty
  a_mod_wait: assert property (p_mod_wait)
    else $error("command issued too soon after a mode setting");

  property p_act_gap;
    (acc && cmd == ddg_pkg::CMD_ACT) |=> !(acc && cmd == ddg_pkg::CMD_ACT) [*3];
  endproperty
  a_act_gap: assert property (p_act_gap)
    else $error("activates closer than four cycles");

  property p_rfc_wait;
    (acc && cmd == ddg_pkg::CMD_REF) |=>
      !(acc && (cmd == ddg_pkg::CMD_REF || cmd == ddg_pkg::CMD_ACT)) [*5];
  endproperty
  a_rfc_wait: assert property (p_rfc_wait)
    else $error("refresh or activate too soon after refresh");

  property p_cke_width;
    $changed(DRAM_CKE) |=> $stable(DRAM_CKE) [*2];
  endproperty
  a_cke_width: assert property (p_cke_width)
    else $error("clock enable level held under three cycles");

  property p_dll_lock;
    is_dll |-> since_srx >= 10'h200;
  endproperty
  a_dll_lock: assert property (p_dll_lock)
    else $error("lock-needing command before lock time");

  property p_xpr_wait;
    (st.state == ddg_pkg::ST_INIT && next_st.cke) |=> !(acc && cmd != ddg_pkg::CMD_NOP) [*5];
  endproperty
  a_xpr_wait: assert property (p_xpr_wait)
    else $error("command too soon after reset exit");

  property p_sr_low;
    (acc && cmd == ddg_pkg::CMD_SRE) |=> !DRAM_CKE [*4];
  endproperty
  a_sr_low: assert property (p_sr_low)
    else $error("self-refresh left before its least low width");

endmodule : ddg_guard

// File: ddg_pkg.sv
// Shared constants, types and decode functions of the DDR3 command timing guard.
package ddg_pkg;

  localparam int CK_PS = 50000;

  // Times in picoseconds or in device clocks, as the device states them.
  localparam int T_AA_MIN_PS = 13090;
  localparam int T_AA_MAX_PS = 20000;
  localparam int T_RCD_PS = 13090;
  localparam int T_RP_PS = 13090;
  localparam int T_RC_PS = 46090;
  localparam int T_RAS_PS = 33000;
  localparam int T_RRD_PS = 5000;
  localparam int T_RRD_NCK = 4;
  localparam int T_FAW_PS = 25000;
  localparam int T_CCD_NCK = 4;
  localparam int T_MRD_NCK = 4;
  localparam int T_MOD_PS = 15000;
  localparam int T_MOD_NCK = 12;
  localparam int T_WTR_PS = 7500;
  localparam int T_WTR_NCK = 4;
  localparam int T_WR_START_NCK = 4;
  localparam int T_RTP_PS = 7500;
  localparam int T_RTP_NCK = 4;
  localparam int T_MPRR_NCK = 1;
  localparam int T_CKE_PS = 5000;
  localparam int T_CKE_NCK = 3;
  localparam int T_CKESR_EXTRA_NCK = 1;
  localparam int T_CKSRE_PS = 10000;
  localparam int T_CKSRE_NCK = 5;
  localparam int T_CKSRX_PS = 10000;
  localparam int T_CKSRX_NCK = 5;
  localparam int T_RFC_PS = 260000;
  localparam int T_XS_EXTRA_PS = 10000;
  localparam int T_XS_NCK = 5;
  localparam int T_DLLK_NCK = 512;
  localparam int T_REFI_PS = 7800000;
  localparam int T_REFI_HOT_PS = 3900000;
  localparam int T_CK_DLL_OFF_PS = 8000;

  function automatic int cyc(input int ps, input int nck);
    int c;
    c = (ps + CK_PS - 1) / CK_PS;
    if (c < nck) begin
      c = nck;
    end
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction : cyc

  localparam int N_RCD = cyc(T_RCD_PS, 1);
  localparam int N_RP = cyc(T_RP_PS, 1);
  localparam int N_RC = cyc(T_RC_PS, 1);
  localparam int N_RAS = cyc(T_RAS_PS, 1);
  localparam int N_RRD = cyc(T_RRD_PS, T_RRD_NCK);
  localparam int N_FAW = cyc(T_FAW_PS, 1);
  localparam int N_CCD = T_CCD_NCK;
  localparam int N_MRD = T_MRD_NCK;
  localparam int N_MOD = cyc(T_MOD_PS, T_MOD_NCK);
  localparam int N_WTR = cyc(T_WTR_PS, T_WTR_NCK);
  localparam int N_RTP = cyc(T_RTP_PS, T_RTP_NCK);
  localparam int N_MPRR = T_MPRR_NCK;
  localparam int N_CKE = cyc(T_CKE_PS, T_CKE_NCK);
  localparam int N_CKESR = N_CKE + T_CKESR_EXTRA_NCK;
  localparam int N_CKSRE = cyc(T_CKSRE_PS, T_CKSRE_NCK);
  localparam int N_CKSRX = cyc(T_CKSRX_PS, T_CKSRX_NCK);
  localparam int N_RFC = cyc(T_RFC_PS, 1);
  localparam int N_XS = cyc(T_RFC_PS + T_XS_EXTRA_PS, T_XS_NCK);
  localparam int N_XPR = N_XS;
  localparam int N_DLLK = T_DLLK_NCK;
  // A longest interval rounds down.
  localparam int N_REFI = T_REFI_PS / CK_PS;
  localparam int N_REFI_HOT = T_REFI_HOT_PS / CK_PS;

  localparam int TW = 10;
  localparam int NB = 8;
  localparam int NK = 5;
  localparam int NF = 4;

  // Global gap timers.
  localparam int G_RRD = 0;
  localparam int G_CCD = 1;
  localparam int G_MRD = 2;
  localparam int G_MOD = 3;
  localparam int G_WTR = 4;
  localparam int G_RFC = 5;
  localparam int G_XS = 6;
  localparam int G_DLL = 7;
  localparam int G_CKE = 8;
  localparam int G_CKESR = 9;
  localparam int G_CKHOLD = 10;
  localparam int G_CKVALID = 11;
  localparam int G_MPR = 12;
  localparam int NG = 13;
  // Per-bank timer kinds.
  localparam int K_RCD = 0;
  localparam int K_RP = 1;
  localparam int K_RC = 2;
  localparam int K_RAS = 3;
  localparam int K_RTP = 4;
  localparam int NT = NG + NK * NB + NF;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_RDA = 4'h3, CMD_WR = 4'h4,
    CMD_WRA = 4'h5, CMD_PRE = 4'h6, CMD_REF = 4'h7, CMD_MRS = 4'h8, CMD_MPR = 4'h9,
    CMD_ODT = 4'ha, CMD_SRE = 4'hb, CMD_SRX = 4'hc, CMD_PDE = 4'hd, CMD_PDX = 4'he
  } ddg_cmd_t;

  typedef enum logic [3:0] {
    ST_INIT = 4'b0001, ST_RUN = 4'b0010, ST_SELF = 4'b0100, ST_DOWN = 4'b1000
  } ddg_state_t;

  // Round a period down to the next valid speed bin.
  function automatic int bin_down(input int ps);
    if (ps >= 3300) return 3300;
    if (ps >= 2500) return 2500;
    if (ps >= 1875) return 1875;
    if (ps >= 1500) return 1500;
    if (ps >= 1250) return 1250;
    return 1070;
  endfunction : bin_down

  // Next smaller standard period used when the least latency is worked out.
  function automatic int std_below(input int ps);
    if (ps >= 2500) return 2500;
    if (ps >= 1875) return 1875;
    if (ps >= 1500) return 1500;
    return 1250;
  endfunction : std_below

  // True when the latency pair is allowed and the running period suits it.
  function automatic logic pair_ok(input logic [3:0] rl, input logic [3:0] wl,
                                   input logic dll_off);
    int lo;
    int hi;
    int rli;
    lo = 0;
    hi = 0;
    rli = int'(rl);
    case ({rl, wl})
      8'h55: begin lo = 3000; hi = 3300; end
      8'h65: begin lo = 2500; hi = 3300; end
      8'h76, 8'h86: begin lo = 1875; hi = 2500; end
      8'h97, 8'ha7: begin lo = 1500; hi = 1875; end
      8'hb8: begin lo = 1250; hi = 1500; end
      8'hd9: begin lo = 1070; hi = 1250; end
      8'hea: begin lo = 938; hi = 1070; end
      default: begin lo = 0; hi = 0; end
    endcase
    if (hi == 0) begin
      return 1'b0;
    end
    if (dll_off) begin
      return CK_PS >= T_CK_DLL_OFF_PS;
    end
    if (hi > bin_down(T_AA_MAX_PS / rli)) begin
      hi = bin_down(T_AA_MAX_PS / rli);
    end
    if (rli < (T_AA_MIN_PS + std_below(CK_PS) - 1) / std_below(CK_PS)) begin
      return 1'b0;
    end
    return (CK_PS >= lo) && (CK_PS <= hi);
  endfunction : pair_ok

endpackage : ddg_pkg

// File: tb.sv
// Self-checking testbench of the command timing guard.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] a; logic [2:0] ba; logic [3:0] b; logic [2:0] bb; int gap;} ddg_row_t;
  logic CLK = 0;
  logic RST_B = 0;
  logic CMD_VALID = 0;
  logic CFG_DLL_OFF = 1;
  logic TEMP_HOT = 0;
  logic CK_RUNNING = 1;
  logic [3:0] CMD_CODE = 4'h0;
  logic [3:0] CFG_READ_LATENCY = 4'h5;
  logic [3:0] CFG_WRITE_LATENCY = 4'h5;
  logic [2:0] CMD_BANK = 3'h0;
  logic CMD_READY, CFG_OK, REFRESH_DUE, CK_HOLD, DRAM_CKE;
  logic [3:0] DRAM_CMD;
  logic [2:0] DRAM_BANK;
  int errs, t0, t1, tr;
  int cyc_n = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  ddg_row_t rows [13];
  ddg_guard i_ddg_guard (.CLK, .RST_B, .CMD_VALID, .CMD_CODE, .CMD_BANK, .CMD_READY,
    .CFG_READ_LATENCY, .CFG_WRITE_LATENCY, .CFG_DLL_OFF, .CFG_OK, .TEMP_HOT, .REFRESH_DUE,
    .CK_RUNNING, .CK_HOLD, .DRAM_CKE, .DRAM_CMD, .DRAM_BANK);
  ddg_dram_model i_ddg_dram_model (.clk(CLK), .rst_b(RST_B), .cke(DRAM_CKE), .cmd(DRAM_CMD),
    .bank(DRAM_BANK), .errs(errs));
  always #25 CLK = ~CLK;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // The whole run needs about 1200 cycles.
  always @(posedge CLK) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 4000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
    end
  endtask : check
  // The request is held until an edge that sees ready; valid stays up for the next caller.
  task automatic take(input logic [3:0] c, input logic [2:0] b, output int t);
    int k;
    k = 0;
    CMD_VALID = 1;
    CMD_CODE = c;
    CMD_BANK = b;
    #39;
    while (CMD_READY !== 1'b1 && k < 2000) begin
      @(posedge CLK);
      #39;
      k++;
    end
    @(posedge CLK);
    #1;
    t = cyc_n;
    check("wait", k == 2000, 0);
  endtask : take
  task automatic idle(input int n);
    CMD_VALID = 0;
    CMD_CODE = 4'h0;
    repeat (n) @(posedge CLK);
    #1;
  endtask : idle
  initial begin
    rows = '{'{4'h1, 3'h0, 4'h2, 3'h0, 1}, '{4'h1, 3'h0, 4'h1, 3'h1, 4},
      '{4'h2, 3'h0, 4'h4, 3'h1, 4}, '{4'h8, 3'h0, 4'h8, 3'h0, 4},
      '{4'h8, 3'h0, 4'h1, 3'h2, 12}, '{4'h4, 3'h0, 4'h2, 3'h0, 13},
      '{4'h2, 3'h0, 4'h6, 3'h0, 4}, '{4'h6, 3'h0, 4'h1, 3'h0, 1},
      '{4'h7, 3'h0, 4'h1, 3'h3, 6}, '{4'h7, 3'h0, 4'h7, 3'h0, 6},
      '{4'h9, 3'h0, 4'h1, 3'h4, 2}, '{4'hd, 3'h0, 4'he, 3'h0, 3},
      '{4'ha, 3'h0, 4'h1, 3'h5, 1}};
    repeat (3) @(posedge CLK);
    #1;
    check("cke", DRAM_CKE, 0);
    check("rdy", CMD_READY, 0);
    RST_B = 1;
    take(4'h1, 3'h0, t0);
    idle(20);
    check("cfg", CFG_OK, 1);
    foreach (rows[i]) begin
      take(rows[i].a, rows[i].ba, t0);
      take(rows[i].b, rows[i].bb, t1);
      check("gap", t1 - t0, rows[i].gap);
      check("cmd", DRAM_CMD, rows[i].b);
      check("bank", DRAM_BANK, rows[i].bb);
      idle(20);
    end
    CMD_VALID = 1;
    CMD_CODE = 4'hf;
    #39;
    check("illegal", CMD_READY, 0);
    @(posedge CLK);
    #1;
    take(4'hb, 3'h0, t0);
    idle(1);
    check("hold", CK_HOLD, 1);
    check("srcke", DRAM_CKE, 0);
    idle(4);
    check("hold", CK_HOLD, 0);
    CK_RUNNING = 0;
    idle(3);
    CK_RUNNING = 1;
    tr = cyc_n;
    take(4'hc, 3'h0, t1);
    check("ckvalid", t1 - tr, 5);
    check("srlow", (t1 - t0) >= 4, 1);
    take(4'h1, 3'h1, t0);
    check("xs", t0 - t1, 6);
    take(4'h2, 3'h1, t0);
    check("xsdll", t0 - t1, 512);
    idle(20);
    for (int h = 0; h < 2; h++) begin
      TEMP_HOT = h[0];
      take(4'h7, 3'h0, t0);
      idle(h ? 70 : 148);
      check("due", REFRESH_DUE, 0);
      idle(10);
      check("due", REFRESH_DUE, 1);
    end
    CFG_DLL_OFF = 0;
    idle(3);
    check("cfg", CFG_OK, 0);
    CFG_DLL_OFF = 1;
    CFG_READ_LATENCY = 4'h6;
    CFG_WRITE_LATENCY = 4'h6;
    idle(3);
    check("cfg", CFG_OK, 0);
    CFG_READ_LATENCY = 4'he;
    CFG_WRITE_LATENCY = 4'ha;
    idle(3);
    check("cfg", CFG_OK, 1);
    check("model", errs, 0);
    stop_test();
  end
endmodule : tb
